// File: hdl/pic_top.sv
// Our own choices: the plain strobed port and the register offsets.
`include "pic_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pic_top (
	input  wire logic              clk_sys,        // system clock, 125 MHz
	input  wire logic              rstn,           // asynchronous reset, active low
	input  wire pic_pkg::pic_bus_t bus,            // register port request
	output pic_pkg::pic_word_t     rdata,          // read data, cycle after read
	input  wire logic [31:0]       fixed_irq,      // fixed-function requests
	input  wire logic [31:0]       logic_irq,      // programmable_logic_array requests
	input  wire logic [31:0]       dma_request,    // dma completion requests
	output pic_pkg::pic_req_t      req,            // request to the core
	output pic_pkg::pic_prio_t     req_prio,       // priority of requested line
	input  wire logic              entry_acknowledge, // core took the request
	input  wire logic              exit_acknowledge   // core finished the handler
);
	import pic_pkg::*;

	localparam int DEPTH = 8;

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	pic_word_t  enable;           // per-line enable state
	pic_word_t  pending;          // per-line pending state
	pic_prio_t  line_priority [32];
	pic_src_t   request_source_select [32];
	pic_word_t  vector_base;
	pic_ctx_t   stack [DEPTH];
	pic_depth_t depth;
	pic_word_t  s1, s2, s3;       // pin synchronisers
	pic_word_t  lvl;              // filtered line level
	pic_word_t  lvl_prev;
	pic_word_t  sel;              // selected request per line
	pic_word_t  edge_mode;        // line uses edge detection
	pic_word_t  hw_set;
	pic_word_t  wait_entry;       // edge arming blocked until entry

	logic      found;
	pic_line_t win_line;
	pic_prio_t win_prio;
	pic_word_t cand;
	logic      preempt_ok;
	pic_ctx_t  top_ctx;

	// ---------------------------------------------
	// input synchronisers: change counts when stages 2 and 3 agree
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1 <= `PIC_RESET_WORD;
			s2 <= `PIC_RESET_WORD;
			s3 <= `PIC_RESET_WORD;
		end else begin
			s1 <= sel;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// filtered level updated only when stages agree
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lvl      <= `PIC_RESET_WORD;
			lvl_prev <= `PIC_RESET_WORD;
		end else begin
			lvl      <= (s2 & s3) | (lvl & (s2 | s3));
			lvl_prev <= lvl;
		end
	end

	// ---------------------------------------------
	// source selection and triggering
	// ---------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_line
			logic sel_g; // selected request of this line
			logic hw_g;  // hardware set of this line
			// pick one of three inputs per line; both logic source codes select logic_irq
			always_comb begin
				unique case (request_source_select[g])
					PIC_SRC_FIXED:       sel_g = fixed_irq[g];
					PIC_SRC_LOGIC_LEVEL: sel_g = logic_irq[g];
					PIC_SRC_LOGIC_EDGE:  sel_g = logic_irq[g];
					PIC_SRC_DMA:         sel_g = dma_request[g];
				endcase
			end
			// each line drives only its own bit, so the vectors have one driver per bit
			assign sel[g]       = sel_g;
			assign edge_mode[g] = (request_source_select[g] != PIC_SRC_LOGIC_LEVEL);
			// rising edge for pulse lines; level lines pend on assertion
			always_comb begin
				if (edge_mode[g])
					hw_g = lvl[g] & ~lvl_prev[g] & ~wait_entry[g];
				else
					hw_g = lvl[g] & ~wait_entry[g] & ~active_line(5'(g));
			end
			assign hw_set[g] = hw_g;
		end
	endgenerate

	// line is on the context stack
	function automatic logic active_line(input pic_line_t l);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < DEPTH; k++)
			if (6'(k) < depth && stack[k].line == l)
				hit = 1'b1;
		return hit;
	endfunction : active_line

	// edges ignored while the line is pending, until entry acknowledge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_entry <= `PIC_RESET_WORD;
		end else begin
			for (int i = 0; i < 32; i++) begin
				if (entry_acknowledge && req.valid && win_line == 5'(i))
					wait_entry[i] <= 1'b0;
				else if (pending[i])
					wait_entry[i] <= 1'b1;
				else
					wait_entry[i] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// enable register
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			enable <= `PIC_RESET_WORD;
		end else if (bus.wr && bus.addr == `PIC_ADDR_ENABLE_SET) begin
			enable <= enable | bus.wdata;
		end else if (bus.wr && bus.addr == `PIC_ADDR_ENABLE_CLEAR) begin
			enable <= enable & ~bus.wdata;
		end
	end

	// ---------------------------------------------
	// pending register
	// ---------------------------------------------
	pic_word_t sw_set, sw_clr, ack_clr, exit_set;
	always_comb begin
		sw_set   = (bus.wr && bus.addr == `PIC_ADDR_PENDING_SET) ? bus.wdata : 32'h0000_0000;
		sw_clr   = (bus.wr && bus.addr == `PIC_ADDR_PENDING_CLR) ? bus.wdata : 32'h0000_0000;
		ack_clr  = (entry_acknowledge && req.valid) ? (32'h0000_0001 << win_line) : 32'h0000_0000;
		exit_set = 32'h0000_0000;
		if (exit_acknowledge && depth != 6'h00 && !edge_mode[top_ctx.line] && lvl[top_ctx.line])
			exit_set = 32'h0000_0001 << top_ctx.line;
	end

	// hardware sets win over every clear; a set while set stays one bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pending <= `PIC_RESET_WORD;
		end else begin
			pending <= ((pending & ~sw_clr & ~ack_clr) | sw_set) | hw_set | exit_set;
		end
	end

	// ---------------------------------------------
	// priority, source and vector registers
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 32; i++) begin
				line_priority[i]         <= `PIC_RESET_PRIO;
				request_source_select[i] <= pic_src_t'(`PIC_RESET_SOURCE);
			end
			vector_base <= `PIC_RESET_VBASE;
		end else if (bus.wr) begin
			// eight 3-bit fields per word, four bits apart
			for (int w = 0; w < 4; w++) begin
				if (bus.addr == `PIC_ADDR_PRIORITY0 + 8'(4 * w))
					for (int f = 0; f < 8; f++)
						line_priority[8 * w + f] <= bus.wdata[4 * f +: 3];
			end
			// sixteen 2-bit fields per word
			for (int w = 0; w < 2; w++) begin
				if (bus.addr == `PIC_ADDR_SOURCE0 + 8'(4 * w))
					for (int f = 0; f < 16; f++)
						request_source_select[16 * w + f] <= pic_src_t'(bus.wdata[2 * f +: 2]);
			end
			if (bus.addr == `PIC_ADDR_VECTOR_BASE)
				vector_base <= bus.wdata;
		end
	end

	// ---------------------------------------------
	// arbitration and request
	// ---------------------------------------------
	assign cand = pending & enable;

	pic_arbiter i_pic_arbiter (
		.cand     (cand),
		.prio     (line_priority),
		.found    (found),
		.win_line (win_line),
		.win_prio (win_prio)
	);

	assign top_ctx    = (depth != 6'h00) ? stack[3'(depth - 6'h01)] : '0;
	// stacked priority is kept, so later priority writes leave service alone
	assign preempt_ok = (depth == 6'h00) || (win_prio < top_ctx.prio);

	always_comb begin
		req.valid  = found && preempt_ok && (depth < 6'(DEPTH));
		req.line   = win_line;
		req.vector = vector_base + {25'h0000000, win_line, 2'h0};
		req_prio   = win_prio;
	end

	// ---------------------------------------------
	// context stack
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			depth <= 6'h00;
			for (int k = 0; k < DEPTH; k++)
				stack[k] <= '0;
		end else if (entry_acknowledge && req.valid) begin
			stack[3'(depth)] <= '{line: win_line, prio: win_prio};
			depth            <= depth + 6'h01;
		end else if (exit_acknowledge && depth != 6'h00) begin
			depth <= depth - 6'h01;
		end
	end

	// ---------------------------------------------
	// read port
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= `PIC_RESET_WORD;
		end else if (bus.rd) begin
			rdata <= 32'h0000_0000;
			if (bus.addr == `PIC_ADDR_ENABLE_SET || bus.addr == `PIC_ADDR_ENABLE_CLEAR)
				rdata <= enable;
			if (bus.addr == `PIC_ADDR_PENDING_SET || bus.addr == `PIC_ADDR_PENDING_CLR)
				rdata <= pending;
			for (int w = 0; w < 4; w++)
				if (bus.addr == `PIC_ADDR_PRIORITY0 + 8'(4 * w))
					for (int f = 0; f < 8; f++)
						rdata[4 * f +: 3] <= line_priority[8 * w + f];
			for (int w = 0; w < 2; w++)
				if (bus.addr == `PIC_ADDR_SOURCE0 + 8'(4 * w))
					for (int f = 0; f < 16; f++)
						rdata[2 * f +: 2] <= request_source_select[16 * w + f];
			if (bus.addr == `PIC_ADDR_VECTOR_BASE)
				rdata <= vector_base;
			if (bus.addr == `PIC_ADDR_STATUS) begin
				rdata[`PIC_STAT_DEPTH_LSB +: 6] <= depth;
				rdata[`PIC_STAT_LINE_LSB +: 5]  <= top_ctx.line;
				rdata[`PIC_STAT_PRIO_LSB +: 3]  <= top_ctx.prio;
				rdata[`PIC_STAT_ACTIVE_BIT]     <= (depth != 6'h00);
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule : pic_top
`default_nettype wire

// File: common/pic_defines.svh
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
// register byte addresses
`define PIC_ADDR_ENABLE_SET   8'h00
`define PIC_ADDR_ENABLE_CLEAR 8'h04
`define PIC_ADDR_PENDING_SET  8'h08
`define PIC_ADDR_PENDING_CLR  8'h0C
`define PIC_ADDR_PRIORITY0    8'h10
`define PIC_ADDR_SOURCE0      8'h20
`define PIC_ADDR_VECTOR_BASE  8'h30
`define PIC_ADDR_STATUS       8'h34
// reset values
`define PIC_RESET_WORD        32'h0000_0000
`define PIC_RESET_PRIO        3'h0
`define PIC_RESET_SOURCE      2'h0
`define PIC_RESET_VBASE       32'h0000_0000
// status field positions
`define PIC_STAT_DEPTH_LSB    0
`define PIC_STAT_LINE_LSB     8
`define PIC_STAT_PRIO_LSB     16
`define PIC_STAT_ACTIVE_BIT   24
`endif

// File: common/pic_pkg.sv
package pic_pkg;
	typedef logic [31:0] pic_word_t;
	typedef logic [4:0]  pic_line_t;
	typedef logic [2:0]  pic_prio_t;
	typedef logic [5:0]  pic_depth_t;
	typedef enum logic [1:0] {PIC_SRC_FIXED, PIC_SRC_LOGIC_LEVEL, PIC_SRC_LOGIC_EDGE, PIC_SRC_DMA} pic_src_t;
	// one stacked context
	typedef struct packed {
		pic_line_t line;
		pic_prio_t prio;
	} pic_ctx_t;
	// request bundle to the core
	typedef struct packed {
		logic      valid;
		pic_line_t line;
		pic_word_t vector;
	} pic_req_t;
	// register port request
	typedef struct packed {
		logic      wr;
		logic      rd;
		logic [7:0] addr;
		pic_word_t wdata;
	} pic_bus_t;
endpackage : pic_pkg

// File: hdl/pic_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module pic_arbiter (
	input  wire logic [31:0]         cand,      // pending and enabled lines
	input  wire pic_pkg::pic_prio_t  prio [32], // per-line priority
	output logic                     found,     // a candidate exists
	output pic_pkg::pic_line_t       win_line,  // winning line
	output pic_pkg::pic_prio_t       win_prio   // its priority
);
	import pic_pkg::*;
	// scan from high line down so lower line number wins ties
	always_comb begin
		found    = 1'b0;
		win_line = 5'h00;
		win_prio = 3'h7;
		for (int i = 31; i >= 0; i--) begin
			if (cand[i] && (!found || prio[i] <= win_prio)) begin
				found    = 1'b1;
				win_line = 5'(i);
				win_prio = prio[i];
			end
		end
	end
endmodule : pic_arbiter
`default_nettype wire

// File: bench/pic_top_asserts.sv
`include "pic_defines.svh"
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------
// port checker for the interrupt controller
// -----------------------------------------
module pic_top_asserts (
	input wire logic               clk_sys,           // system clock
	input wire logic               rstn,              // reset, active low
	input wire pic_pkg::pic_bus_t  bus,               // register port request
	input wire pic_pkg::pic_word_t rdata,             // read data
	input wire pic_pkg::pic_req_t  req,               // request to the core
	input wire pic_pkg::pic_prio_t req_prio,          // requested priority
	input wire logic               entry_acknowledge, // entry pulse
	input wire logic               exit_acknowledge   // exit pulse
);
	import pic_pkg::*;
	pic_word_t en_m;       // enable mirror
	pic_word_t vbase_m;    // vector base mirror
	pic_word_t prio_m [4]; // priority word mirror
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// mirror what software wrote, so outputs can be judged against it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			en_m <= '0;
			vbase_m <= '0;
			prio_m <= '{default: '0};
		end else if (bus.wr) begin
			if (bus.addr == `PIC_ADDR_ENABLE_SET) en_m <= en_m | bus.wdata;
			if (bus.addr == `PIC_ADDR_ENABLE_CLEAR) en_m <= en_m & ~bus.wdata;
			if (bus.addr == `PIC_ADDR_VECTOR_BASE) vbase_m <= bus.wdata;
			if (bus.addr[7:4] == 4'h1 && bus.addr[1:0] == 2'b00) prio_m[bus.addr[3:2]] <= bus.wdata;
		end
	end
	AST_RESET_QUIET: assert property ($rose(rstn) |-> !req.valid)
		else $error("request live after reset");
	AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == '0)
		else $error("read data outside read answer");
	AST_EN_READ: assert property (bus.rd && (bus.addr == `PIC_ADDR_ENABLE_SET
		|| bus.addr == `PIC_ADDR_ENABLE_CLEAR) |=> rdata == $past(en_m))
		else $error("enable readback wrong");
	AST_UNMAPPED: assert property (bus.rd && bus.addr == 8'h40 |=> rdata == '0)
		else $error("unmapped read not zero");
	AST_ONLY_ENABLED: assert property (req.valid |-> en_m[req.line])
		else $error("disabled line requested");
	AST_VECTOR: assert property (req.valid |-> req.vector == vbase_m + {25'h0, req.line, 2'b00})
		else $error("vector address wrong");
	AST_PRIO: assert property (req.valid |-> req_prio == prio_m[req.line[4:3]][{req.line[2:0], 2'b00} +: 3])
		else $error("request priority wrong");
	AST_NEST_URGENT: assert property (entry_acknowledge && req.valid
		|=> !req.valid || req_prio < $past(req_prio))
		else $error("non-urgent request during handler");
	COV_ENTRY: cover property (entry_acknowledge && req.valid);
	COV_EXIT: cover property (exit_acknowledge);
	COV_TOP_PRIO: cover property (req.valid && req_prio == 3'h0);
endmodule : pic_top_asserts
`default_nettype wire

// File: bench/pic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// core stand-in: takes requests, leaves on call
// ---------------------------------------------
module pic_core_model (
	input wire logic              clk_sys,   // system clock
	input wire logic              rstn,      // reset, active low
	input wire pic_pkg::pic_req_t req,       // request from controller
	input wire logic              take_on,   // accept requests
	input wire logic              leave,     // leave handler
	output logic                  entry_ack, // entry pulse
	output logic                  exit_ack   // exit pulse
);
	import pic_pkg::*;
	// one-cycle entry on a live request, never beside an exit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			entry_ack <= 1'b0;
			exit_ack <= 1'b0;
		end else begin
			entry_ack <= take_on && req.valid && !entry_ack && !leave;
			exit_ack <= leave;
		end
	end
endmodule : pic_core_model
`default_nettype wire

// File: bench/tb_pic_top.sv
`include "pic_defines.svh"
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------
// bench for the interrupt controller
// ----------------------------------
module tb_pic_top;
	import pic_pkg::*;
	localparam logic [7:0] ES = `PIC_ADDR_ENABLE_SET;
	localparam logic [7:0] EC = `PIC_ADDR_ENABLE_CLEAR;
	localparam logic [7:0] PS = `PIC_ADDR_PENDING_SET;
	localparam logic [7:0] PC = `PIC_ADDR_PENDING_CLR;
	localparam logic [7:0] ST = `PIC_ADDR_STATUS;
	logic      clk_sys, rstn, take_on, leave, ent, ext;
	pic_bus_t  bus;
	pic_word_t rdata, fixed_irq, logic_irq, dma_request;
	pic_req_t  req;
	pic_prio_t req_prio;
	int        n_errors, checks_done;
	pic_top i_pic_top (.clk_sys, .rstn, .bus, .rdata, .fixed_irq, .logic_irq, .dma_request, .req,
		.req_prio, .entry_acknowledge(ent), .exit_acknowledge(ext));
	pic_core_model i_pic_core_model (.clk_sys, .rstn, .req, .take_on, .leave, .entry_ack(ent), .exit_ack(ext));
	// clock, 8 ns period
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// compare and count
	task automatic chk(input pic_word_t s, input pic_word_t e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// register port accesses, strobes one cycle long
	task automatic wr(input logic [7:0] a, input pic_word_t d);
		@(posedge clk_sys) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input pic_word_t e);
		@(posedge clk_sys) bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_sys) bus <= '0;
		#1 chk(rdata, e);
	endtask : rd
	// request word: valid, priority, line
	task automatic rq(input pic_word_t e);
		@(posedge clk_sys) #1 chk(pic_word_t'({req.valid, req_prio, req.line}), e);
	endtask : rq
	task automatic nq;
		@(posedge clk_sys) #1 chk(pic_word_t'(req.valid), 32'h0);
	endtask : nq
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle
	task automatic ex;
		@(posedge clk_sys) leave <= 1'b1;
		@(posedge clk_sys) leave <= 1'b0;
	endtask : ex
	task automatic wait_req;
		repeat (40) begin
			@(posedge clk_sys) #1;
			if (req.valid === 1'b1) break;
		end
		if (req.valid !== 1'b1) begin
			n_errors++;
			$display("BAD t=%0t no request", $time);
			tally_and_finish();
		end
	endtask : wait_req
	// main sequence
	initial begin
		rstn = 1'b0;
		take_on = 1'b0;
		leave = 1'b0;
		bus = '0;
		fixed_irq = '0;
		logic_irq = '0;
		dma_request = '0;
		idle(20);
		rstn <= 1'b1;
		rd(ES, 32'h0);
		rd(PS, 32'h0);
		rd(ST, 32'h0);
		rd(8'h40, 32'h0);
		$display("reset test done");
		wr(ES, 32'hF0);
		wr(EC, 32'h30);
		wr(ES, 32'h0);
		rd(ES, 32'hC0);
		rd(EC, 32'hC0);
		$display("enable test done");
		wr(PS, 32'h100);
		wr(PS, 32'h100);
		rd(PC, 32'h100);
		nq();
		wr(PC, 32'h100);
		rd(PS, 32'h0);
		$display("pending test done");
		wr(`PIC_ADDR_VECTOR_BASE, 32'h0000_1000);
		wr(`PIC_ADDR_PRIORITY0, 32'h1303_0000);
		wr(PS, 32'hD0);
		wait_req();
		rq(32'h127);
		chk(req.vector, 32'h0000_101C);
		wr(ES, 32'h10);
		wr(`PIC_ADDR_PRIORITY0, 32'h3303_0000);
		rq(32'h164);
		$display("arbitration test done");
		@(posedge clk_sys) take_on <= 1'b1;
		idle(4);
		rd(PS, 32'hC0);
		nq();
		wr(`PIC_ADDR_PRIORITY0, 32'h3305_0000);
		wr(ES, 32'h1);
		wr(PS, 32'h1);
		idle(4);
		rd(ST, 32'h0100_0002);
		@(posedge clk_sys) take_on <= 1'b0;
		ex();
		rd(ST, 32'h0103_0401);
		ex();
		wait_req();
		rq(32'h166);
		$display("nesting test done");
		wr(EC, 32'hFFFF_FFFF);
		wr(PC, 32'hFFFF_FFFF);
		wr(`PIC_ADDR_SOURCE0, 32'h60);
		wr(ES, 32'hC);
		@(posedge clk_sys) logic_irq <= 32'h4;
		idle(8);
		rd(PS, 32'h4);
		rq(32'h102);
		@(posedge clk_sys) take_on <= 1'b1;
		idle(4);
		@(posedge clk_sys) logic_irq <= 32'h8;
		idle(8);
		@(posedge clk_sys) logic_irq <= 32'hC;
		idle(8);
		rd(PS, 32'hC);
		@(posedge clk_sys) take_on <= 1'b0;
		ex();
		wait_req();
		rq(32'h102);
		wr(PC, 32'h4);
		rq(32'h103);
		@(posedge clk_sys) take_on <= 1'b1;
		idle(4);
		@(posedge clk_sys) take_on <= 1'b0;
		rd(PS, 32'h0);
		ex();
		idle(8);
		rd(PS, 32'h8);
		$display("source test done");
		// a pending clear lands on the very edge at which a new pulse pends line 2
		@(posedge clk_sys) logic_irq <= 32'h8;
		idle(8);
		@(posedge clk_sys) logic_irq <= 32'hC;
		idle(3);
		wr(PC, 32'h4);
		rd(PS, 32'hC);
		$display("collision test done");
		// reset again with lines pending and enabled
		@(posedge clk_sys) rstn <= 1'b0;
		idle(2);
		rstn <= 1'b1;
		rd(ES, 32'h0);
		rd(PS, 32'h0);
		rd(ST, 32'h0);
		nq();
		$display("second reset test done");
		tally_and_finish();
	end
endmodule : tb_pic_top
bind pic_top pic_top_asserts i_pic_top_asserts (.clk_sys, .rstn, .bus, .rdata, .req, .req_prio,
	.entry_acknowledge, .exit_acknowledge);
`default_nettype wire
